//--- hw/ssf_top.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ssf_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slave_select_n,
	input wire logic shift_busy,
	input wire logic shift_byte_done,
	input wire logic [7:0] shift_rx_data,
	output logic shift_load,
	output logic [7:0] shift_tx_data,
	output logic select_is_gpio,
	output logic master_mode,
	output logic master_sclk,
	output logic master_sclk_edge,
	output logic irq
);
	// ****************************************
	// Register state
	// ****************************************
	logic rx_full_irq_en, master_select, spi_enable, tx_empty_irq_en;
	logic error_irq_en, select_fault_detect_en;
	logic [1:0] rate_select;
	logic rx_full_flag, overrun_flag, select_fault_flag, tx_empty_flag;
	logic [7:0] rx_buf, tx_buf;
	logic ovr_arm, fault_arm;
	logic ss_n_q;
	logic aw_held, w_held;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_go, rd_go;
	logic [7:0] wr_addr, rd_addr;
	logic [7:0] wr_byte;
	logic wr_lane0;
	logic wr_ok, rd_ok;
	logic wr_ctl, wr_st, wr_data, rd_st, rd_data;
	logic [7:0] next_rdata;
	logic fault_event;

	// ****************************************
	// Write channel capture
	// ****************************************
	// Address and data may arrive in either order; each is held until both are in
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	assign wr_addr = aw_held ? aw_addr_q : s_axi_awaddr;
	assign wr_byte = w_held ? w_data_q[7:0] : s_axi_wdata[7:0];
	assign wr_lane0 = w_held ? w_strb_q[0] : s_axi_wstrb[0];

	// Hold whichever half came first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
		end else if (ce) begin
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_held <= 1'b1;
					aw_addr_q <= s_axi_awaddr;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_held <= 1'b1;
					w_data_q <= s_axi_wdata;
					w_strb_q <= s_axi_wstrb;
				end
			end
		end
	end

	// Address decode, word aligned only
	always_comb begin
		wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr[7:2] >= ssf_pkg::IDX_CONTROL[5:0])
			&& (wr_addr[7:2] <= ssf_pkg::IDX_DATA[5:0]);
		rd_ok = (rd_addr[1:0] == 2'h0) && (rd_addr[7:2] >= ssf_pkg::IDX_CONTROL[5:0])
			&& (rd_addr[7:2] <= ssf_pkg::IDX_DATA[5:0]);
		wr_ctl = wr_go && wr_lane0 && wr_ok && (wr_addr[7:2] == ssf_pkg::IDX_CONTROL[5:0]);
		wr_st = wr_go && wr_lane0 && wr_ok && (wr_addr[7:2] == ssf_pkg::IDX_STATUS[5:0]);
		wr_data = wr_go && wr_lane0 && wr_ok && (wr_addr[7:2] == ssf_pkg::IDX_DATA[5:0]);
		rd_st = rd_go && (rd_addr[7:2] == ssf_pkg::IDX_STATUS[5:0]) && rd_ok;
		rd_data = rd_go && (rd_addr[7:2] == ssf_pkg::IDX_DATA[5:0]) && rd_ok;
	end

	// Write response one cycle after both halves are taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= ssf_pkg::RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign rd_addr = s_axi_araddr;

	// Read mux of live state
	always_comb begin
		next_rdata = 8'h00;
		if (rd_addr[7:2] == ssf_pkg::IDX_CONTROL[5:0]) begin
			next_rdata[ssf_pkg::CTL_RX_IE] = rx_full_irq_en;
			next_rdata[ssf_pkg::CTL_MASTER] = master_select;
			next_rdata[ssf_pkg::CTL_ENABLE] = spi_enable;
			next_rdata[ssf_pkg::CTL_TX_IE] = tx_empty_irq_en;
		end else if (rd_addr[7:2] == ssf_pkg::IDX_STATUS[5:0]) begin
			next_rdata[ssf_pkg::ST_RX_FULL] = rx_full_flag;
			next_rdata[ssf_pkg::ST_ERR_IE] = error_irq_en;
			next_rdata[ssf_pkg::ST_OVERRUN] = overrun_flag;
			next_rdata[ssf_pkg::ST_FAULT] = select_fault_flag;
			next_rdata[ssf_pkg::ST_TX_EMPTY] = tx_empty_flag;
			next_rdata[ssf_pkg::ST_FAULT_EN] = select_fault_detect_en;
			next_rdata[ssf_pkg::ST_RATE_HI] = rate_select[1];
			next_rdata[ssf_pkg::ST_RATE_LO] = rate_select[0];
		end else if (rd_addr[7:2] == ssf_pkg::IDX_DATA[5:0]) begin
			// reads see the receive side only
			next_rdata = rx_buf;
		end
	end

	// Read data registered, one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= ssf_pkg::RESP_OKAY;
		end else if (ce) begin
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? {24'h0, next_rdata} : 32'h0;
				s_axi_rresp <= rd_ok ? ssf_pkg::RESP_OKAY : ssf_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control and configuration bits
	// ****************************************
	// reset leaves master selected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_full_irq_en <= ssf_pkg::CTL_RESET[ssf_pkg::CTL_RX_IE];
			master_select <= ssf_pkg::CTL_RESET[ssf_pkg::CTL_MASTER];
			spi_enable <= ssf_pkg::CTL_RESET[ssf_pkg::CTL_ENABLE];
			tx_empty_irq_en <= ssf_pkg::CTL_RESET[ssf_pkg::CTL_TX_IE];
		end else if (ce && wr_ctl) begin
			rx_full_irq_en <= wr_byte[ssf_pkg::CTL_RX_IE];
			master_select <= wr_byte[ssf_pkg::CTL_MASTER];
			spi_enable <= wr_byte[ssf_pkg::CTL_ENABLE];
			tx_empty_irq_en <= wr_byte[ssf_pkg::CTL_TX_IE];
		end
	end

	// rate code and enables clear at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			error_irq_en <= 1'b0;
			select_fault_detect_en <= 1'b0;
			rate_select <= 2'h0;
		end else if (ce && wr_st) begin
			error_irq_en <= wr_byte[ssf_pkg::ST_ERR_IE];
			select_fault_detect_en <= wr_byte[ssf_pkg::ST_FAULT_EN];
			rate_select <= {wr_byte[ssf_pkg::ST_RATE_HI], wr_byte[ssf_pkg::ST_RATE_LO]};
		end
	end

	// ****************************************
	// Receive side
	// ****************************************
	// buffers carry no reset value
	always_ff @(posedge aclk) begin
		if (ce && shift_byte_done && !rx_full_flag) begin
			rx_buf <= shift_rx_data;
		end
	end

	// set on byte arrival; set wins over a same-cycle read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_full_flag <= 1'b0;
		end else if (ce) begin
			if (shift_byte_done && !rx_full_flag) begin
				rx_full_flag <= 1'b1;
			end else if (rd_data) begin
				rx_full_flag <= 1'b0;
			end
		end
	end

	// Status reads arm the clear sequences for flags seen set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ovr_arm <= 1'b0;
			fault_arm <= 1'b0;
		end else if (ce) begin
			if (rd_st) begin
				ovr_arm <= overrun_flag;
				fault_arm <= select_fault_flag;
			end else begin
				if (rd_data) begin
					ovr_arm <= 1'b0;
				end
				if (wr_data) begin
					fault_arm <= 1'b0;
				end
			end
		end
	end

	// second byte while full is lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun_flag <= 1'b0;
		end else if (ce) begin
			if (shift_byte_done && rx_full_flag) begin
				overrun_flag <= 1'b1;
			// cleared only by armed data read
			end else if (rd_data && ovr_arm) begin
				overrun_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// Slave select and mode fault
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ss_n_q <= 1'b1;
		end else if (ce) begin
			ss_n_q <= slave_select_n;
		end
	end

	// detection enable gates only the setting
	always_comb begin
		fault_event = 1'b0;
		if (spi_enable && select_fault_detect_en) begin
			if (master_select) begin
				// any low level on a master
				fault_event = !slave_select_n;
			end else begin
				fault_event = slave_select_n && !ss_n_q && shift_busy;
			end
		end
	end

	// armed data write clears; a fresh fault wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			select_fault_flag <= 1'b0;
		end else if (ce) begin
			if (fault_event) begin
				select_fault_flag <= 1'b1;
			end else if (wr_data && fault_arm) begin
				select_fault_flag <= 1'b0;
			end
		end
	end

	// pin freed when disabled or for master without detection; never for an enabled slave
	assign select_is_gpio = !spi_enable || (master_select && !select_fault_detect_en);
	assign master_mode = master_select;

	// ****************************************
	// Transmit side
	// ****************************************
	// writes fill the transmit buffer
	always_ff @(posedge aclk) begin
		if (ce && wr_data) begin
			tx_buf <= wr_byte;
		end
	end

	// hand-over waits for the shifter to go idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_load <= 1'b0;
			shift_tx_data <= 8'h00;
		end else if (ce) begin
			shift_load <= 1'b0;
			if (!tx_empty_flag && !shift_busy && !shift_load && spi_enable) begin
				shift_load <= 1'b1;
				shift_tx_data <= tx_buf;
			end
		end
	end

	// set at hand-over, reset value is empty; two-cycle refill
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_empty_flag <= 1'b1;
		end else if (ce) begin
			if (wr_data) begin
				tx_empty_flag <= 1'b0;
			end else if (shift_load) begin
				tx_empty_flag <= 1'b1;
			end
		end
	end

	// ****************************************
	// Master clock and interrupt
	// ****************************************
	ssf_rate_div #(
		.CNT_W(8)
	) u_rate_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.run(spi_enable && master_select && shift_busy),
		.rate_select(rate_select),
		.sclk(master_sclk),
		.sclk_edge(master_sclk_edge)
	);

	// one request line; gate each source
	assign irq = (rx_full_flag && rx_full_irq_en) || (tx_empty_flag && tx_empty_irq_en)
		|| ((overrun_flag || select_fault_flag) && error_irq_en);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_rx_full_set: assert property (ce && shift_byte_done |=> rx_full_flag)
		else $error("receive full not set after byte");
	a_rx_clear_read: assert property (ce && rd_data && !shift_byte_done |=> !rx_full_flag)
		else $error("data read did not clear receive full");
	a_overrun_keep: assert property (ce && shift_byte_done && rx_full_flag
		|=> overrun_flag && rx_buf == $past(rx_buf))
		else $error("overrun did not keep old byte");
	a_overrun_hold: assert property ($fell(overrun_flag) |-> $past(rd_data && ovr_arm))
		else $error("overrun cleared without sequence");
	a_fault_master: assert property (ce && spi_enable && master_select
		&& select_fault_detect_en && !slave_select_n |=> select_fault_flag)
		else $error("master fault missed");
	a_fault_gate: assert property ($rose(select_fault_flag) |-> $past(select_fault_detect_en))
		else $error("fault set while detection off");
	a_fault_clear: assert property ($fell(select_fault_flag) |-> $past(wr_data && fault_arm))
		else $error("fault cleared without sequence");
	a_load_idle: assert property (shift_load |-> $past(!shift_busy))
		else $error("load while shifter busy");
	a_tx_refill: assert property (ce && wr_data && !shift_busy && spi_enable
		##1 (ce && !shift_busy)[*2] |=> tx_empty_flag)
		else $error("transmit empty not back within two cycles");
	a_err_gate: assert property (!error_irq_en && !(rx_full_flag && rx_full_irq_en)
		&& !(tx_empty_flag && tx_empty_irq_en) |-> !irq)
		else $error("error flags raised interrupt while masked");

	c_overrun: cover property (shift_byte_done && rx_full_flag);
	c_fault_clear: cover property (rd_st && select_fault_flag ##[1:20] wr_data);
	c_two_queued: cover property (shift_load ##[1:5] wr_data);
endmodule

//--- hw/ssf_pkg.sv
// ****************************************
// Shared constants of the serial flag block
// ****************************************
package ssf_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'h10;
	localparam logic [7:0] IDX_STATUS = 8'h11;
	localparam logic [7:0] IDX_DATA = 8'h12;
	localparam int ADDR_W = 8;

	// Control register fields
	localparam int CTL_RX_IE = 7;
	localparam int CTL_MASTER = 5;
	localparam int CTL_ENABLE = 1;
	localparam int CTL_TX_IE = 0;
	localparam logic [7:0] CTL_RESET = 8'h20;

	// Status register fields
	localparam int ST_RX_FULL = 7;
	localparam int ST_ERR_IE = 6;
	localparam int ST_OVERRUN = 5;
	localparam int ST_FAULT = 4;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_FAULT_EN = 2;
	localparam int ST_RATE_HI = 1;
	localparam int ST_RATE_LO = 0;

	// Rate divisors for the four rate_select codes
	localparam logic [7:0] DIV_0 = 8'h02;
	localparam logic [7:0] DIV_1 = 8'h08;
	localparam logic [7:0] DIV_2 = 8'h20;
	localparam logic [7:0] DIV_3 = 8'h80;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- hw/ssf_rate_div.sv
`timescale 1ns/1ps
// ****************************************
// Master serial clock divider
// ****************************************
module ssf_rate_div #(
	parameter int CNT_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic run,
	input wire logic [1:0] rate_select,
	output logic sclk,
	output logic sclk_edge
);
	logic [CNT_W-1:0] divisor;
	logic [CNT_W-1:0] count;

	always_comb begin
		case (rate_select)
			2'h0: divisor = CNT_W'(ssf_pkg::DIV_0);
			2'h1: divisor = CNT_W'(ssf_pkg::DIV_1);
			2'h2: divisor = CNT_W'(ssf_pkg::DIV_2);
			default: divisor = CNT_W'(ssf_pkg::DIV_3);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			sclk <= 1'b0;
			sclk_edge <= 1'b0;
		end else if (ce) begin
			sclk_edge <= 1'b0;
			if (!run) begin
				count <= '0;
				sclk <= 1'b0;
			end else if (count == divisor - CNT_W'(1)) begin
				count <= '0;
				sclk <= ~sclk;
				sclk_edge <= 1'b1;
			end else begin
				count <= count + CNT_W'(1);
			end
		end
	end
endmodule

//--- verification/ssf_shift_model.sv
`timescale 1ns/1ps
// ****************************************
// Shift engine stand-in for the flag block
// ****************************************
module ssf_shift_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic shift_load,
	input wire logic [7:0] shift_tx_data,
	input wire logic [15:0] busy_len,
	input wire logic rx_go,
	input wire logic [7:0] rx_byte,
	output logic shift_busy,
	output logic shift_byte_done,
	output logic [7:0] shift_rx_data,
	output logic [7:0] last_tx
);
	logic [15:0] left;

	// Busy the cycle after a load; busy_len makes a prompt or a slow engine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shift_busy <= 1'b0;
			left <= 16'h0000;
		end else if (shift_load) begin
			shift_busy <= 1'b1;
			left <= busy_len;
			last_tx <= shift_tx_data;
		end else if (left > 16'h0001) begin
			left <= left - 16'h0001;
		end else begin
			shift_busy <= 1'b0;
			left <= 16'h0000;
		end
	end

	// Byte valid for the done cycle only; lines invert after so stale data matches only every other cycle
	always_ff @(posedge aclk) begin
		shift_byte_done <= aresetn & rx_go;
		if (!aresetn) begin
			shift_rx_data <= 8'h00;
		end else if (rx_go) begin
			shift_rx_data <= rx_byte;
		end else begin
			shift_rx_data <= ~shift_rx_data;
		end
	end
endmodule

//--- verification/tb.sv
`timescale 1ns/1ps
// ****************************************
// Bench for the serial flag block
// ****************************************
module tb;
	localparam logic [7:0] A_CTL = ssf_pkg::IDX_CONTROL << 2;
	localparam logic [7:0] A_ST = ssf_pkg::IDX_STATUS << 2;
	localparam logic [7:0] A_DAT = ssf_pkg::IDX_DATA << 2;
	localparam logic [1:0] OK = ssf_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = ssf_pkg::RESP_SLVERR;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] q;
		logic [1:0] r;
		logic i;
	} ssf_row_s;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic slave_select_n = 1'b1;
	logic rx_go = 1'b0;
	logic [7:0] rx_byte = 8'h00;
	logic [15:0] busy_len = 16'h0028;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, q;
	logic shift_busy, shift_byte_done, shift_load, select_is_gpio, master_mode;
	logic master_sclk, master_sclk_edge, irq;
	logic [7:0] shift_rx_data, shift_tx_data, last_tx;
	int fails = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;
	ssf_row_s rows [8] = '{
		'{A_CTL, 8'h20, 8'h20, OK, 1'b0},
		'{A_CTL, 8'h21, 8'h21, OK, 1'b1},
		'{A_CTL, 8'hA2, 8'hA2, OK, 1'b0},
		'{A_ST, 8'hFC, 8'h4C, OK, 1'b0},
		'{A_ST, 8'h01, 8'h09, OK, 1'b0},
		'{A_ST, 8'h02, 8'h0A, OK, 1'b0},
		'{A_ST, 8'h03, 8'h0B, OK, 1'b0},
		'{8'h4C, 8'hFF, 8'h00, ERR, 1'b0}};

	ssf_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slave_select_n, .shift_busy,
		.shift_byte_done, .shift_rx_data, .shift_load, .shift_tx_data, .select_is_gpio,
		.master_mode, .master_sclk, .master_sclk_edge, .irq);
	ssf_shift_model u_engine (.aclk, .aresetn, .shift_load, .shift_tx_data, .busy_len,
		.rx_go, .rx_byte, .shift_busy, .shift_byte_done, .shift_rx_data, .last_tx);

	// Clock and hang guard, limit far above the few thousand cycles used
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails = fails + 1;
			summarize();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// Bus cycles hold every half until its own ready, then wait for the answer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		q = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rd(a);
		chk(q, {24'h000000, e});
	endtask

	task automatic rx(input logic [7:0] b);
		@(posedge aclk);
		rx_go <= 1'b1;
		rx_byte <= b;
		@(posedge aclk);
		rx_go <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// data reads are never expected before a byte, nor written back
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			chk(resp, rows[k].r);
			rd(rows[k].a);
			chk(resp, rows[k].r);
			chk(q, {24'h000000, rows[k].q});
			chk(irq, rows[k].i);
		end
		$display("test rows done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(master_mode, 1'b1);
		chk(select_is_gpio, 1'b1);
		chk(irq, 1'b0);
		rdc(A_CTL, ssf_pkg::CTL_RESET);
		rdc(A_ST, 8'h08);
		$display("test reset done");
		// divisor per code and idle hand-over
		busy_len <= 16'h0258;
		wr(A_CTL, 8'h22);
		for (int c = 0; c < 4; c++) begin
			wr(A_ST, 8'(c));
			wr(A_DAT, 8'hA5 ^ 8'(c));
			rdc(A_ST, 8'h08 | 8'(c));
			chk(last_tx, 8'hA5 ^ 8'(c));
			while (master_sclk_edge !== 1'b1) @(posedge aclk);
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (master_sclk_edge !== 1'b1);
			chk(n, 2 << (2 * c));
			while (shift_busy === 1'b1) @(posedge aclk);
		end
		$display("test rate done");
		// second byte waits for the busy engine
		busy_len <= 16'h0028;
		wr(A_DAT, 8'h11);
		wr(A_DAT, 8'h22);
		rdc(A_ST, 8'h03);
		chk(last_tx, 8'h11);
		while (shift_busy === 1'b1) @(posedge aclk);
		repeat (3) @(posedge aclk);
		chk(last_tx, 8'h22);
		rdc(A_ST, 8'h0B);
		$display("test queue done");
		wr(A_CTL, 8'hA2);
		wr(A_ST, 8'h40);
		rx(8'h3C);
		chk(irq, 1'b1);
		rdc(A_ST, 8'hC8);
		rx(8'hC3);
		rdc(A_ST, 8'hE8);
		rdc(A_DAT, 8'h3C);
		rdc(A_ST, 8'h48);
		rx(8'h5A);
		rdc(A_DAT, 8'h5A);
		rdc(A_ST, 8'h48);
		chk(irq, 1'b0);
		// error enable gates the overrun request
		wr(A_CTL, 8'h22);
		wr(A_ST, 8'h00);
		rx(8'h01);
		rx(8'h02);
		chk(irq, 1'b0);
		wr(A_ST, 8'h40);
		chk(irq, 1'b1);
		rd(A_ST);
		rd(A_DAT);
		$display("test receive done");
		// master select fault and its clear
		wr(A_ST, 8'h04);
		chk(select_is_gpio, 1'b0);
		slave_select_n <= 1'b0;
		repeat (3) @(posedge aclk);
		slave_select_n <= 1'b1;
		rdc(A_ST, 8'h1C);
		wr(A_ST, 8'h00);
		chk(select_is_gpio, 1'b1);
		rdc(A_ST, 8'h18);
		wr(A_DAT, 8'h33);
		rdc(A_ST, 8'h08);
		slave_select_n <= 1'b0;
		repeat (3) @(posedge aclk);
		rdc(A_ST, 8'h08);
		slave_select_n <= 1'b1;
		$display("test master fault done");
		// slave fault when select rises mid-byte
		wr(A_CTL, 8'h02);
		@(posedge aclk);
		chk(master_mode, 1'b0);
		chk(select_is_gpio, 1'b0);
		wr(A_ST, 8'h07);
		slave_select_n <= 1'b0;
		wr(A_DAT, 8'h44);
		repeat (4) @(posedge aclk);
		slave_select_n <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(master_sclk, 1'b0);
		// Byte 0x44 still waits behind the busy engine, so transmit empty stays low
		rdc(A_ST, 8'h17);
		chk(last_tx, 8'h33);
		wr(A_ST, 8'h00);
		chk(select_is_gpio, 1'b0);
		$display("test slave fault done");
		// queued byte goes out once the engine is idle
		while (shift_busy === 1'b1) @(posedge aclk);
		repeat (3) @(posedge aclk);
		chk(last_tx, 8'h44);
		// clock enable low and a masked lane leave state alone
		ce <= 1'b0;
		rx(8'h77);
		ce <= 1'b1;
		rdc(A_ST, 8'h18);
		s_axi_wstrb <= 4'hE;
		wr(A_ST, 8'h40);
		s_axi_wstrb <= 4'hF;
		chk(resp, OK);
		rdc(A_ST, 8'h18);
		$display("test freeze done");
		summarize();
	end
endmodule
